/* File: rtl/acl_window_pkg.sv */
// Constants for the per-port access-control table window
package acl_window_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [11:0] IDX_STAGE_FIRST = 12'h600; // Staging byte at offset 0
    localparam logic [11:0] IDX_REMARK_LOW = 12'h60b; // Remark LSB and map mode
    localparam logic [11:0] IDX_SPARE = 12'h60c; // Spare staging byte
    localparam logic [11:0] IDX_FWD_MAP = 12'h60d; // Forwarding port map
    localparam logic [11:0] IDX_RULESET_HI = 12'h60e; // Ruleset upper byte
    localparam logic [11:0] IDX_RULESET_LO = 12'h60f; // Ruleset lower byte
    localparam logic [11:0] IDX_SEL_HIGH = 12'h610; // Byte select, staging 0..7
    localparam logic [11:0] IDX_SEL_LOW = 12'h611; // Byte select, staging 8..F, launches
    localparam logic [11:0] IDX_CONTROL = 12'h612; // Transfer control and status
    localparam int ADDR_SHIFT = 2; // Word per register
    // ------------------------------------------------------------
    // Staging byte positions and fields
    // ------------------------------------------------------------
    localparam int STAGE_BYTES = 16; // Staging bytes per entry
    localparam int STAGE_REMARK_HI = 10; // Holds remark priority [2:1] in bits 1:0
    localparam int STAGE_REMARK_LO = 11; // Holds remark priority [0] in bit 7
    localparam int STAGE_FWD = 13; // Forwarding map byte
    localparam int STAGE_RULE_HI = 14; // Ruleset [15:8]
    localparam int STAGE_RULE_LO = 15; // Ruleset [7:0]
    localparam int REMARK_LSB_BIT = 7; // Remark priority LSB position
    localparam int MAP_MODE_LSB = 5; // Map mode field, bits 6:5
    localparam int FWD_WIDTH = 7; // Forward map bits 6:0
    // ------------------------------------------------------------
    // Control register fields and reset values
    // ------------------------------------------------------------
    localparam int CTL_WR_STATUS = 6; // Write complete flag
    localparam int CTL_RD_STATUS = 5; // Read complete flag
    localparam int CTL_DIR = 4; // 1 = write, 0 = read
    localparam int INDEX_WIDTH = 4; // Table entry index width
    localparam logic [7:0] STAGE_RESET = 8'h00; // Staging reset value
    localparam logic [7:0] SEL_RESET = 8'h00; // Byte select reset value
    localparam logic [3:0] INDEX_RESET = 4'h0; // Entry index reset value
    localparam int XFER_CYCLES_DEF = 4; // Table access latency in clocks
endpackage

/* File: rtl/ahb_reg_port.sv */
// AHB-Lite slave front end: address phase capture and registered read data
`timescale 1ns/1ps
`default_nettype none
module ahb_reg_port
    import acl_window_pkg::*;
(
    input wire logic mclk, // System clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // 1 = write
    input wire logic [2:0] hsize, // Transfer size, word only
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready in
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Always ready
    output logic hresp, // Always OKAY
    input wire logic [7:0] rd_value, // Read value for haddr
    output logic [11:0] wr_index, // Register index of write
    output logic [7:0] wr_data, // Write byte
    output logic wr_strobe // One-cycle write pulse
);
    // ------------------------------------------------------------
    // Address phase capture
    // ------------------------------------------------------------
    logic take; // Valid transfer accepted this edge
    logic wr_pend; // Write data phase pending
    logic [11:0] wr_idx_q; // Captured index
    assign take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1; // No wait states; every register answers at once
    assign hresp = 1'b0;

    // Latch write intent so data is taken in the next cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_pend <= 1'b0;
            wr_idx_q <= 12'h000;
        end else begin
            wr_pend <= take && hwrite;
            if (take) begin
                wr_idx_q <= haddr[13:2];
            end
        end
    end

    // Read data fetched at address phase so it stands through the data phase
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata <= {24'h00_0000, rd_value};
        end
    end

    assign wr_strobe = wr_pend;
    assign wr_index = wr_idx_q;
    assign wr_data = hwdata[7:0]; // Upper lanes ignored, registers are 8 bits
endmodule
`default_nettype wire

/* File: rtl/acl_table_store.sv */
// Flip-flop storage of the access-control table with per-byte write mask
`timescale 1ns/1ps
`default_nettype none
module acl_table_store
    import acl_window_pkg::*;
#(
    parameter int ENTRIES = 16 // Number of table entries
)
(
    input wire logic mclk, // System clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic [INDEX_WIDTH-1:0] index, // Entry addressed
    input wire logic store, // Write pulse
    input wire logic [STAGE_BYTES-1:0] mask, // Bit i enables byte i
    input wire logic [8*STAGE_BYTES-1:0] wdata, // Byte i at [8i+:8]
    output logic [8*STAGE_BYTES-1:0] rdata // Entry content
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [8*STAGE_BYTES-1:0] mem [ENTRIES]; // Table entries

    // Masked update; disabled bytes keep their old content
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            for (int e = 0; e < ENTRIES; e++) begin
                mem[e] <= '0;
            end
        end else if (store) begin
            for (int b = 0; b < STAGE_BYTES; b++) begin
                if (mask[b]) begin
                    mem[index][8*b +: 8] <= wdata[8*b +: 8];
                end
            end
        end
    end

    assign rdata = mem[index];
endmodule
`default_nettype wire

/* File: rtl/acl_indirect_access_regs.sv */
// Indirect access window to one port's access-control table over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module acl_indirect_access_regs
    import acl_window_pkg::*;
#(
    parameter int XFER_CYCLES = XFER_CYCLES_DEF, // Clocks per table transfer
    parameter int ENTRIES = 16 // Table depth
)
(
    input wire logic mclk, // 25 MHz system clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB byte address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write flag
    input wire logic [2:0] hsize, // AHB size
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB ready in
    output logic [31:0] hrdata, // AHB read data
    output logic hreadyout, // AHB ready out
    output logic hresp, // AHB response
    output logic [2:0] remark_priority, // Staged remark priority
    output logic [1:0] map_mode, // Staged map mode
    output logic [FWD_WIDTH-1:0] port_forward_mask, // Staged forward map, bit 0 = port 1
    output logic [15:0] ruleset, // Staged ruleset
    output logic transfer_busy // Table transfer in progress
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam int CNT_W = $clog2(XFER_CYCLES + 1); // Counter width
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(XFER_CYCLES - 1); // Final count

    logic [7:0] stage [STAGE_BYTES]; // Staging bytes 0..F
    logic [7:0] sel_high; // Byte select [15:8]
    logic [7:0] sel_low; // Byte select [7:0]
    logic dir_write; // Direction bit
    logic [INDEX_WIDTH-1:0] table_entry_index; // Entry for next transfer
    logic wr_done; // Write status flag
    logic rd_done; // Read status flag
    logic busy; // Transfer in progress
    logic [CNT_W-1:0] cnt; // Transfer cycle count
    logic xfer_write; // Direction snapshot
    logic [INDEX_WIDTH-1:0] xfer_index; // Index snapshot
    logic [STAGE_BYTES-1:0] xfer_mask; // Byte mask snapshot, bit i = staging byte i
    logic finish; // Last cycle of a transfer
    logic launch; // Accepted launch
    logic [11:0] wr_index; // Bus write index
    logic [7:0] wr_data; // Bus write byte
    logic wr_strobe; // Bus write pulse
    logic [7:0] rd_value; // Read mux output
    logic [8*STAGE_BYTES-1:0] stage_flat; // Staging bytes for the store
    logic [8*STAGE_BYTES-1:0] entry_data; // Addressed entry content
    logic [7:0] control_value; // Control register readback

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Staging byte i is enabled by select bit 15-i across both registers
    function automatic logic [STAGE_BYTES-1:0] byte_mask(input logic [7:0] hi,
                                                        input logic [7:0] lo);
        logic [15:0] sel;
        logic [STAGE_BYTES-1:0] m;
        sel = {hi, lo};
        m = '0;
        for (int i = 0; i < STAGE_BYTES; i++) begin
            m[i] = sel[15 - i];
        end
        return m;
    endfunction

    // True when a 12-bit index falls within the staging bytes
    function automatic logic is_stage(input logic [11:0] idx);
        return idx >= IDX_STAGE_FIRST && idx <= IDX_RULESET_LO;
    endfunction

    // ------------------------------------------------------------
    // Bus front end and table storage
    // ------------------------------------------------------------
    ahb_reg_port u_port (
        .mclk(mclk),
        .nrst(nrst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .rd_value(rd_value),
        .wr_index(wr_index),
        .wr_data(wr_data),
        .wr_strobe(wr_strobe)
    );

    always_comb begin
        for (int i = 0; i < STAGE_BYTES; i++) begin
            stage_flat[8*i +: 8] = stage[i];
        end
    end

    acl_table_store #(
        .ENTRIES(ENTRIES)
    ) u_store (
        .mclk(mclk),
        .nrst(nrst),
        .index(xfer_index),
        .store(finish && xfer_write),
        .mask(xfer_mask),
        .wdata(stage_flat),
        .rdata(entry_data)
    );

    // ------------------------------------------------------------
    // Launch and transfer sequencing
    // ------------------------------------------------------------
    // A launch during a running transfer is dropped; the host must wait
    // Read data is captured in the address phase, so a read pipelined right
    // behind a write to the same register returns the old value
    assign launch = wr_strobe && wr_index == IDX_SEL_LOW && !busy;
    assign finish = busy && cnt == CNT_LAST;

    // Snapshot of direction, index and mask so software may rewrite control and select freely; staging bytes are used live at finish
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busy <= 1'b0;
            cnt <= '0;
            xfer_write <= 1'b0;
            xfer_index <= INDEX_RESET;
            xfer_mask <= '0;
        end else if (launch) begin
            busy <= 1'b1;
            cnt <= '0;
            xfer_write <= dir_write;
            xfer_index <= table_entry_index;
            xfer_mask <= byte_mask(sel_high, wr_data);
        end else if (finish) begin
            busy <= 1'b0;
            cnt <= '0;
        end else if (busy) begin
            cnt <= cnt + 1'b1;
        end
    end

    // Status flags: only the launched direction's flag cleared at launch, both set on completion
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_done <= 1'b1;
            rd_done <= 1'b1;
        end else if (launch) begin
            wr_done <= !dir_write;
            rd_done <= dir_write;
        end else if (finish) begin
            wr_done <= 1'b1;
            rd_done <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    // Select and control fields
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sel_high <= SEL_RESET;
            sel_low <= SEL_RESET;
            dir_write <= 1'b0;
            table_entry_index <= INDEX_RESET;
        end else if (wr_strobe) begin
            case (wr_index)
                IDX_SEL_HIGH: sel_high <= wr_data;
                IDX_SEL_LOW: sel_low <= wr_data;
                IDX_CONTROL: begin
                    dir_write <= wr_data[CTL_DIR];
                    table_entry_index <= wr_data[INDEX_WIDTH-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Staging bytes; a read completion beats a bus write to the same byte
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < STAGE_BYTES; i++) begin
                stage[i] <= STAGE_RESET;
            end
        end else begin
            for (int i = 0; i < STAGE_BYTES; i++) begin
                if (finish && !xfer_write && xfer_mask[i]) begin
                    stage[i] <= entry_data[8*i +: 8];
                end else if (wr_strobe && is_stage(wr_index)
                             && wr_index[3:0] == 4'(i)) begin
                    stage[i] <= wr_data;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Read mux and staged field outputs
    // ------------------------------------------------------------
    assign control_value = {1'b0, wr_done, rd_done, dir_write, table_entry_index};

    // Unmapped addresses read as zero with an OKAY response
    always_comb begin
        rd_value = 8'h00;
        if (is_stage(haddr[13:2])) begin
            rd_value = stage[haddr[5:2]];
        end else begin
            case (haddr[13:2])
                IDX_SEL_HIGH: rd_value = sel_high;
                IDX_SEL_LOW: rd_value = sel_low;
                IDX_CONTROL: rd_value = control_value;
                default: rd_value = 8'h00;
            endcase
        end
    end

    assign remark_priority = {stage[STAGE_REMARK_HI][1:0],
                              stage[STAGE_REMARK_LO][REMARK_LSB_BIT]};
    assign map_mode = stage[STAGE_REMARK_LO][MAP_MODE_LSB +: 2];
    assign port_forward_mask = stage[STAGE_FWD][FWD_WIDTH-1:0];
    assign ruleset = {stage[STAGE_RULE_HI], stage[STAGE_RULE_LO]};
    assign transfer_busy = busy;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    remark_lsb_a: assert property (@(posedge mclk) disable iff (!nrst)
        remark_priority[0] == stage[STAGE_REMARK_LO][7]
        && remark_priority[2:1] == stage[STAGE_REMARK_HI][1:0])
        else $error("remark priority bits misplaced");

    forward_map_a: assert property (@(posedge mclk) disable iff (!nrst)
        wr_strobe && wr_index == IDX_FWD_MAP && !finish
        |=> port_forward_mask == $past(wr_data[6:0]))
        else $error("forward map not taken from write");

    launch_start_a: assert property (@(posedge mclk) disable iff (!nrst)
        launch |=> busy && xfer_index == $past(table_entry_index)
        && xfer_write == $past(dir_write))
        else $error("launch did not start transfer");

    high_select_a: assert property (@(posedge mclk) disable iff (!nrst)
        launch |=> xfer_mask[7] == $past(sel_high[0]) && xfer_mask[0] == $past(sel_high[7]))
        else $error("high select mapping wrong");

    low_select_a: assert property (@(posedge mclk) disable iff (!nrst)
        launch |=> xfer_mask[15] == $past(wr_data[0]) && xfer_mask[8] == $past(wr_data[7]))
        else $error("low select mapping wrong");

    write_status_a: assert property (@(posedge mclk) disable iff (!nrst)
        launch && dir_write |=> !wr_done [*4] ##1 wr_done)
        else $error("write status timing wrong");

    read_status_a: assert property (@(posedge mclk) disable iff (!nrst)
        launch && !dir_write |=> !rd_done [*4] ##1 rd_done)
        else $error("read status timing wrong");

    masked_read_a: assert property (@(posedge mclk) disable iff (!nrst)
        finish && !xfer_write && !xfer_mask[STAGE_RULE_LO] && !wr_strobe
        |=> $stable(stage[STAGE_RULE_LO]))
        else $error("disabled staging byte changed by read");

    masked_write_a: assert property (@(posedge mclk) disable iff (!nrst)
        finish && xfer_write && !xfer_mask[0]
        |=> entry_data[7:0] == $past(entry_data[7:0]))
        else $error("disabled table byte changed by write");

    idle_status_a: assert property (@(posedge mclk) disable iff (!nrst)
        !busy |-> wr_done && rd_done)
        else $error("status low while idle");

    // Completion data paths, watched at the ruleset low byte
    read_load_a: assert property (@(posedge mclk) disable iff (!nrst)
        finish && !xfer_write && xfer_mask[STAGE_RULE_LO]
        |=> stage[STAGE_RULE_LO] == $past(entry_data[8*STAGE_RULE_LO +: 8]))
        else $error("enabled staging byte not loaded by read");

    write_store_a: assert property (@(posedge mclk) disable iff (!nrst)
        finish && xfer_write && xfer_mask[STAGE_RULE_LO]
        |=> entry_data[8*STAGE_RULE_LO +: 8] == $past(stage[STAGE_RULE_LO]))
        else $error("enabled table byte not stored by write");

    launch_drop_a: assert property (@(posedge mclk) disable iff (!nrst)
        wr_strobe && wr_index == IDX_SEL_LOW && busy
        |=> $stable(xfer_mask) && $stable(xfer_index))
        else $error("launch taken while busy");
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the access-control table window over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module tb
    import acl_window_pkg::*;
;
    // ------------------------------------------------------------
    // Clock, reset and bus signals
    // ------------------------------------------------------------
    logic mclk = 1'b0; // 25 MHz clock
    logic nrst = 1'b0; // Reset, active low
    logic hsel = 1'b0; // Slave select
    logic [31:0] haddr = 32'h0; // Byte address
    logic [1:0] htrans = 2'b00; // Transfer type
    logic hwrite = 1'b0; // Write flag
    logic [2:0] hsize = 3'b010; // Always a whole word
    logic [31:0] hwdata = 32'h0; // Write data
    logic [31:0] hrdata; // Read data
    logic hreadyout; // Slave ready, also the bus ready
    logic hresp; // Response, OKAY expected
    logic [2:0] remark_priority; // Staged remark priority
    logic [1:0] map_mode; // Staged map mode
    logic [FWD_WIDTH-1:0] port_forward_mask; // Staged forward map
    logic [15:0] ruleset; // Staged ruleset
    logic transfer_busy; // Table transfer running
    int mismatches = 0; // Failed comparisons
    int check_count = 0; // All comparisons

    always #20 mclk = ~mclk; // Half of a 40 ns period

    // Single slave, so its ready is the bus ready
    acl_indirect_access_regs #(.XFER_CYCLES(4), .ENTRIES(16)) u_acl_indirect_access_regs (
        .mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .remark_priority(remark_priority), .map_mode(map_mode),
        .port_forward_mask(port_forward_mask), .ruleset(ruleset),
        .transfer_busy(transfer_busy));

    // ------------------------------------------------------------
    // Comparison, verdict and bus tasks
    // ------------------------------------------------------------
    // Case equality so an unknown never passes for a match
    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("Counts: %0d checks, %0d mismatches", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Upper data bits carry junk on purpose: only the low byte may count
    task automatic bus_write(input logic [11:0] idx, input logic [7:0] data);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= 1'b1;
        haddr <= {18'h0, idx, 2'b00};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= {24'ha5a5a5, data};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        check_val("write response", 32'h0, {31'h0, hresp});
    endtask

    // Read data is taken at the edge that closes the data phase
    task automatic bus_read(input logic [11:0] idx, output logic [31:0] got);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= 1'b0;
        haddr <= {18'h0, idx, 2'b00};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        got = hrdata;
    endtask

    task automatic read_check(input string what, input logic [11:0] idx, input logic [7:0] exp);
        logic [31:0] v;
        bus_read(idx, v);
        check_val(what, {24'h0, exp}, v);
    endtask

    // Status must read 0 first, then reach 1 within a bounded number of polls
    task automatic wait_done(input int bitpos);
        logic [31:0] v;
        int n;
        #1;
        check_val("busy after launch", 32'h1, {31'h0, transfer_busy});
        bus_read(IDX_CONTROL, v);
        check_val("status while running", 32'h0, {31'h0, v[bitpos]});
        n = 0;
        while (v[bitpos] !== 1'b1 && n < 20) begin
            bus_read(IDX_CONTROL, v);
            n++;
        end
        check_val("status when done", 32'h1, {31'h0, v[bitpos]});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        read_check("control at reset", IDX_CONTROL, 8'h60);
        read_check("select high at reset", IDX_SEL_HIGH, 8'h00);
        read_check("select low at reset", IDX_SEL_LOW, 8'h00);
        read_check("spare at reset", IDX_SPARE, 8'h00);
        read_check("ruleset low at reset", IDX_RULESET_LO, 8'h00);
        $display("test reset done");
    endtask

    // Remark split over two bytes; forward bit 7 lies outside the map
    task automatic test_fields();
        bus_write(IDX_STAGE_FIRST + 12'ha, 8'h01);
        bus_write(IDX_REMARK_LOW, 8'hc0);
        bus_write(IDX_FWD_MAP, 8'h81);
        bus_write(IDX_RULESET_HI, 8'h12);
        bus_write(IDX_RULESET_LO, 8'h34);
        #1;
        check_val("remark priority", 32'h3, {29'h0, remark_priority});
        check_val("map mode", 32'h2, {30'h0, map_mode});
        check_val("forward map", 32'h01, {25'h0, port_forward_mask});
        check_val("ruleset", 32'h1234, {16'h0, ruleset});
        read_check("remark byte readback", IDX_REMARK_LOW, 8'hc0);
        $display("test fields done");
    endtask

    // Partial write of entry 3, then a wider read shows the untouched byte
    task automatic test_write_read();
        bus_write(IDX_RULESET_LO, 8'h11);
        bus_write(IDX_RULESET_HI, 8'h22);
        bus_write(IDX_FWD_MAP, 8'h33);
        bus_write(IDX_STAGE_FIRST, 8'h44);
        bus_write(IDX_CONTROL, 8'h13);
        bus_write(IDX_SEL_HIGH, 8'h00);
        bus_write(IDX_SEL_LOW, 8'h03);
        wait_done(CTL_WR_STATUS);
        read_check("control after write", IDX_CONTROL, 8'h73);
        bus_write(IDX_RULESET_LO, 8'h00);
        bus_write(IDX_RULESET_HI, 8'h00);
        bus_write(IDX_FWD_MAP, 8'h99);
        bus_write(IDX_CONTROL, 8'h03);
        bus_write(IDX_SEL_LOW, 8'h07);
        wait_done(CTL_RD_STATUS);
        read_check("entry byte F", IDX_RULESET_LO, 8'h11);
        read_check("entry byte E", IDX_RULESET_HI, 8'h22);
        read_check("entry byte D unwritten", IDX_FWD_MAP, 8'h00);
        $display("test write read done");
    endtask

    // High select reaches bytes 7 and 0; byte F of entry 9 stays clear
    task automatic test_high_select();
        bus_write(IDX_STAGE_FIRST + 12'h7, 8'h5a);
        bus_write(IDX_STAGE_FIRST, 8'hc3);
        bus_write(IDX_RULESET_LO, 8'h77);
        bus_write(IDX_CONTROL, 8'h19);
        bus_write(IDX_SEL_HIGH, 8'h81);
        bus_write(IDX_SEL_LOW, 8'h00);
        wait_done(CTL_WR_STATUS);
        bus_write(IDX_STAGE_FIRST + 12'h7, 8'h00);
        bus_write(IDX_STAGE_FIRST, 8'h00);
        bus_write(IDX_CONTROL, 8'h09);
        bus_write(IDX_SEL_LOW, 8'h01);
        wait_done(CTL_RD_STATUS);
        read_check("entry byte 7", IDX_STAGE_FIRST + 12'h7, 8'h5a);
        read_check("entry byte 0", IDX_STAGE_FIRST, 8'hc3);
        read_check("entry byte F masked", IDX_RULESET_LO, 8'h00);
        $display("test high select done");
    endtask

    // Read with byte F disabled, then a second launch while busy is dropped
    task automatic test_dropped_launch();
        bus_write(IDX_RULESET_LO, 8'h5c);
        bus_write(IDX_CONTROL, 8'h09);
        bus_write(IDX_SEL_LOW, 8'h00);
        bus_write(IDX_SEL_LOW, 8'h01);
        #1;
        check_val("busy over dropped launch", 32'h1, {31'h0, transfer_busy});
        read_check("select low kept", IDX_SEL_LOW, 8'h01);
        read_check("status after drop", IDX_CONTROL, 8'h69);
        read_check("byte F not enabled", IDX_RULESET_LO, 8'h5c);
        $display("test dropped launch done");
    endtask

    // Unmapped place reads zero; status bits ignore writes
    task automatic test_odd_access();
        bus_write(12'h7ff, 8'hff);
        read_check("unmapped read", 12'h7ff, 8'h00);
        bus_write(IDX_CONTROL, 8'h00);
        read_check("status write ignored", IDX_CONTROL, 8'h60);
        $display("test odd access done");
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        test_reset();
        test_fields();
        test_write_read();
        test_high_select();
        test_dropped_launch();
        test_odd_access();
        finish_test();
    end

    // Tests need well under 2000 cycles; a hang is cut off far beyond that
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        finish_test();
    end
endmodule
`default_nettype wire
